/* src/hiwt_pkg.sv */
// Purpose: Shared constants for the hard-iron offset and wrist tilt bank.
// Assumes: 7-bit register addresses, 8-bit register data, 10 MHz clock.
// Notes:   Offset bytes are indexed 0..5 as X low, X high, Y low, Y high,
//          Z low, Z high.
package hiwt_pkg;

   localparam int unsigned HIWT_ADDR_W = 7;
   localparam int unsigned HIWT_DATA_W = 8;
   localparam int unsigned HIWT_NUM_OFFS = 6;

   ////////////////////////////////////////////////////////////////////////
   // Register addresses; offsets live in bank A, tilt settings in bank B
   localparam logic [5:0][6:0] HIWT_OFFS_ADDR = {
      7'h32, 7'h31, 7'h30, 7'h2F, 7'h2E, 7'h2D
   };
   localparam logic [6:0] HIWT_ADDR_TILT_LAT = 7'h50;
   localparam logic [6:0] HIWT_ADDR_TILT_THS = 7'h54;
   localparam logic [6:0] HIWT_ADDR_TILT_MASK = 7'h59;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] HIWT_OFFS_RST = 8'h00;
   localparam logic [7:0] HIWT_LAT_RST = 8'h0F;
   localparam logic [7:0] HIWT_THS_RST = 8'h20;
   localparam logic [5:0] HIWT_MASK_RST = 6'h30;

   ////////////////////////////////////////////////////////////////////////
   // Mask register layout: six enables in bits 7..2, bits 1..0 read zero
   localparam int unsigned HIWT_MASK_LSB = 2;
   localparam int unsigned HIWT_MASK_W = 6;
   localparam logic [1:0] HIWT_MASK_PAD = 2'h0;
   localparam logic [7:0] HIWT_RD_NONE = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Units and timing
   localparam int unsigned HIWT_LAT_LSB_MS = 40;
   localparam int unsigned HIWT_THS_LSB_NANO_G = 15625000;
   localparam int unsigned HIWT_CLK_HZ = 10000000;
   localparam int unsigned HIWT_TICK_CYCLES =
      HIWT_CLK_HZ / 1000 * HIWT_LAT_LSB_MS;
   localparam int unsigned HIWT_TICK_W = 19;

endpackage

/* src/hiwt_cfg_if.sv */
// Purpose: Carries write strobes and stored values between bank parts.
// Assumes: All signals on i_mclk.
// Notes:   Decoder owns the strobes, storage modules own the values.
interface hiwt_cfg_if;
   import hiwt_pkg::*;

   logic [7:0] wdata;
   logic [5:0] wr_offs;
   logic wr_lat;
   logic wr_ths;
   logic wr_mask;
   logic [7:0] offs_byte [6];
   logic [7:0] lat;
   logic [7:0] ths;
   logic [5:0] mask;

   modport ctl (output wdata, wr_offs, wr_lat, wr_ths, wr_mask,
      input offs_byte, lat, ths, mask);
   modport offs (input wdata, wr_offs, output offs_byte);
   modport tilt (input wdata, wr_lat, wr_ths, wr_mask,
      output lat, ths, mask);
endinterface

/* src/hiwt_offset.sv */
// Purpose: Six hard-iron offset byte registers.
// Assumes: Strobes are already bank and address qualified.
// Notes:   One byte register per generate entry.
module hiwt_offset
   import hiwt_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   hiwt_cfg_if.offs cfg
);

   ////////////////////////////////////////////////////////////////////////
   // Byte storage, cleared at reset, rewritable at any time
   for (genvar k = 0; k < HIWT_NUM_OFFS; k++) begin : g_byte
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            cfg.offs_byte[k] <= HIWT_OFFS_RST; // see R3
         end else if (cfg.wr_offs[k]) begin
            cfg.offs_byte[k] <= cfg.wdata; // see R2
         end
      end
   end

endmodule

/* src/hiwt_tilt.sv */
// Purpose: Wrist tilt latency, threshold and direction mask registers.
// Assumes: Strobes are already bank and address qualified.
// Notes:   Mask keeps only the six enables; pad bits are not stored.
module hiwt_tilt
   import hiwt_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   hiwt_cfg_if.tilt cfg
);

   ////////////////////////////////////////////////////////////////////////
   // Latency, counted in 40 ms steps
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg.lat <= HIWT_LAT_RST; // see R4
      end else if (cfg.wr_lat) begin
         cfg.lat <= cfg.wdata; // see R10
      end
   end

   // Threshold, counted in 15.625 mg steps
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg.ths <= HIWT_THS_RST; // see R5
      end else if (cfg.wr_ths) begin
         cfg.ths <= cfg.wdata; // see R10
      end
   end

   // Direction enables; X on, Y and Z off after reset
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg.mask <= HIWT_MASK_RST; // see R7 see R8
      end else if (cfg.wr_mask) begin
         cfg.mask <= cfg.wdata[HIWT_MASK_LSB +: HIWT_MASK_W]; // see R6
      end
   end

endmodule

/* src/hiwt_regs.sv */
// Purpose: Hard-iron offset and wrist tilt configuration register bank.
// Assumes: Register port driven by the serial interface logic on i_mclk;
//          i_bank_b comes from the bank select logic on the same clock.
// Notes:   Reads are answered one cycle later; unmapped reads give zero.
// Behaviour
// R1: Each axis offset is one signed 16-bit two's complement word.
// R2: X, Y, Z offset bytes are readable and writable any time.
// R3: All offset bytes reset to zero.
// R4: Latency is 8-bit, 40 ms per count, resets to 0Fh.
// R5: Threshold is 8-bit, 15.625 mg per count, resets to 20h.
// R6: Mask holds six direction enables; one enables, zero disables.
// R7: Positive and negative X enables reset to one.
// R8: Y and Z enables reset to zero.
// R9: Tilt registers sit in bank B, apart from the offsets in bank A.
// R10: Latency, threshold and mask are readable and writable.
// R11: High byte gives bits 15..8, low byte bits 7..0.
// R12: Software writes zero to mask pad bits; they read back zero.
module hiwt_regs
   import hiwt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = HIWT_TICK_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_bank_b,
   input wire logic [6:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic signed [15:0] o_x_offset,
   output logic signed [15:0] o_y_offset,
   output logic signed [15:0] o_z_offset,
   output logic [7:0] o_tilt_latency,
   output logic [7:0] o_tilt_threshold,
   output logic [5:0] o_tilt_mask,
   output logic o_tilt_latency_tick
);

   hiwt_cfg_if cfg ();

   ////////////////////////////////////////////////////////////////////////
   // Address decode; bank qualifies every hit
   logic [5:0] hit_offs;
   logic hit_lat;
   logic hit_ths;
   logic hit_mask;
   logic hit_any;

   for (genvar k = 0; k < HIWT_NUM_OFFS; k++) begin : g_hit
      assign hit_offs[k] = !i_bank_b && (i_addr == HIWT_OFFS_ADDR[k]);
   end

   // Same address in the wrong bank must not alias
   assign hit_lat = i_bank_b && (i_addr == HIWT_ADDR_TILT_LAT); // see R9
   assign hit_ths = i_bank_b && (i_addr == HIWT_ADDR_TILT_THS); // see R9
   assign hit_mask = i_bank_b && (i_addr == HIWT_ADDR_TILT_MASK); // see R9
   assign hit_any = (|hit_offs) || hit_lat || hit_ths || hit_mask;

   ////////////////////////////////////////////////////////////////////////
   // Write strobes toward the storage modules
   assign cfg.wdata = i_wdata;
   assign cfg.wr_offs = {HIWT_NUM_OFFS{i_wr}} & hit_offs; // see R2
   assign cfg.wr_lat = i_wr && hit_lat; // see R10
   assign cfg.wr_ths = i_wr && hit_ths; // see R10
   assign cfg.wr_mask = i_wr && hit_mask; // see R10

   hiwt_offset u_offset (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .cfg(cfg)
   );

   hiwt_tilt u_tilt (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .cfg(cfg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read selection as an AND-OR tree; one hit at most per address
   logic [7:0] offs_term [6];
   logic [7:0] rd_offs;
   logic [7:0] rd_tilt;
   logic [7:0] mask_word;
   logic [7:0] next_rdata;

   for (genvar k = 0; k < HIWT_NUM_OFFS; k++) begin : g_rd
      assign offs_term[k] = {8{hit_offs[k]}} & cfg.offs_byte[k];
   end

   assign rd_offs = offs_term[0] | offs_term[1] | offs_term[2]
      | offs_term[3] | offs_term[4] | offs_term[5]; // see R2
   // Pad bits are not stored, so they always read zero
   assign mask_word = {cfg.mask, HIWT_MASK_PAD}; // see R12
   assign rd_tilt = ({8{hit_lat}} & cfg.lat)
      | ({8{hit_ths}} & cfg.ths)
      | ({8{hit_mask}} & mask_word); // see R10
   assign next_rdata = hit_any ? (rd_offs | rd_tilt) : HIWT_RD_NONE;

   // Read data is registered; a same-cycle write is seen on the next read
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= HIWT_RD_NONE;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Offset words: high byte on top, low byte below, two's complement
   assign o_x_offset = {cfg.offs_byte[1], cfg.offs_byte[0]}; // see R1 R11
   assign o_y_offset = {cfg.offs_byte[3], cfg.offs_byte[2]}; // see R1 R11
   assign o_z_offset = {cfg.offs_byte[5], cfg.offs_byte[4]}; // see R1 R11

   assign o_tilt_latency = cfg.lat;
   assign o_tilt_threshold = cfg.ths;
   assign o_tilt_mask = cfg.mask; // see R6

   ////////////////////////////////////////////////////////////////////////
   // Latency step enable: one pulse per 40 ms so the detector can count
   // latency units without a clock of its own
   logic [18:0] tick_cnt;
   logic tick_wrap;
   logic [18:0] next_tick_cnt;

   assign tick_wrap = (tick_cnt == 19'(TICK_CYCLES - 1)); // see R4
   assign next_tick_cnt = tick_wrap ? 19'h00000 : tick_cnt + 19'h00001;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt <= 19'h00000;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tilt_latency_tick <= 1'b0;
      end else begin
         o_tilt_latency_tick <= tick_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // Helper: offset bytes written this cycle
   logic offs_wr_any;
   assign offs_wr_any = |cfg.wr_offs;

   offs_word_a: assert property ( // see R11
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[1])
      |=> (o_x_offset[15:8] == $past(i_wdata))
         && (o_x_offset[7:0] == $past(o_x_offset[7:0])))
      else $error("X high byte did not land in bits 15..8");

   offs_sign_a: assert property ( // see R1
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[5] && i_wdata[7])
      |=> (o_z_offset < 0))
      else $error("Z offset with high bit set is not negative");

   offs_hold_a: assert property ( // see R2
      !offs_wr_any |=> $stable(o_x_offset) && $stable(o_y_offset)
         && $stable(o_z_offset))
      else $error("Offset changed without a write");

   offs_rdback_a: assert property ( // see R2
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[2])
      ##1 (i_rd && !i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[2])
      |=> o_rvalid && (o_rdata == $past(i_wdata, 2)))
      else $error("Y low byte did not read back");

   offs_reset_a: assert property ( // see R3
      @(posedge i_mclk) disable iff (1'b0)
      !i_rst_n |=> (o_x_offset == 16'h0000) && (o_y_offset == 16'h0000)
         && (o_z_offset == 16'h0000))
      else $error("Offsets not zero after reset");

   tilt_reset_a: assert property ( // see R4 R5
      @(posedge i_mclk) disable iff (1'b0)
      !i_rst_n |=> (o_tilt_latency == 8'h0F)
         && (o_tilt_threshold == 8'h20))
      else $error("Latency or threshold reset value wrong");

   mask_reset_a: assert property ( // see R7 R8
      @(posedge i_mclk) disable iff (1'b0)
      !i_rst_n |=> (o_tilt_mask == 6'h30))
      else $error("Mask reset value wrong");

   mask_write_a: assert property ( // see R6
      (i_wr && i_bank_b && i_addr == HIWT_ADDR_TILT_MASK)
      |=> (o_tilt_mask == $past(i_wdata[7:2])))
      else $error("Mask enables not taken from bits 7..2");

   tilt_write_a: assert property ( // see R10
      (i_wr && i_bank_b && i_addr == HIWT_ADDR_TILT_THS)
      |=> (o_tilt_threshold == $past(i_wdata))
         && $stable(o_tilt_latency))
      else $error("Threshold write went astray");

   bank_sep_a: assert property ( // see R9
      (i_wr && !i_bank_b && i_addr == HIWT_ADDR_TILT_LAT)
      |=> $stable(o_tilt_latency) && $stable(o_tilt_mask))
      else $error("Bank A write reached a tilt register");

   mask_pad_a: assert property ( // see R12
      (i_rd && i_bank_b && i_addr == HIWT_ADDR_TILT_MASK)
      |=> o_rvalid && (o_rdata[1:0] == 2'h0)
         && (o_rdata[7:2] == $past(o_tilt_mask)))
      else $error("Mask read back wrong or pad bits not zero");

   unmapped_rd_a: assert property (
      (i_rd && !hit_any) |=> o_rvalid && (o_rdata == 8'h00))
      else $error("Unmapped read did not return zero");

   tick_gap_a: assert property ( // see R4
      o_tilt_latency_tick |=> !o_tilt_latency_tick)
      else $error("Latency tick longer than one cycle");

   ////////////////////////////////////////////////////////////////////////
   // Word halves, bank separation, latency write, read timing and tick spacing
   // Helper: cycles since the last tick, kept apart from the divider so a
   // broken wrap compare cannot hide behind its own counter
   logic [18:0] tick_gap;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_gap <= 19'h00000;
      end else if (o_tilt_latency_tick) begin
         tick_gap <= 19'h00001;
      end else begin
         tick_gap <= tick_gap + 19'h00001;
      end
   end

   tick_space_a: assert property ( // see R4
      o_tilt_latency_tick == (tick_gap == 19'(TICK_CYCLES)))
      else $error("Latency tick not spaced by the step count");

   offs_low_a: assert property ( // see R11
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[0])
      |=> (o_x_offset[7:0] == $past(i_wdata))
         && (o_x_offset[15:8] == $past(o_x_offset[15:8])))
      else $error("X low byte did not land in bits 7..0");

   y_word_a: assert property ( // see R11
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[3])
      |=> (o_y_offset[15:8] == $past(i_wdata)))
      else $error("Y high byte did not land in bits 15..8");

   z_word_a: assert property ( // see R11
      (i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[4])
      |=> (o_z_offset[7:0] == $past(i_wdata)))
      else $error("Z low byte did not land in bits 7..0");

   // Bank B writes at offset addresses must leave the offsets alone
   offs_bank_a: assert property ( // see R9
      (i_wr && i_bank_b && i_addr == HIWT_OFFS_ADDR[0])
      |=> $stable(o_x_offset))
      else $error("Bank B write reached an offset byte");

   lat_write_a: assert property ( // see R10
      (i_wr && i_bank_b && i_addr == HIWT_ADDR_TILT_LAT)
      |=> (o_tilt_latency == $past(i_wdata))
         && $stable(o_tilt_threshold))
      else $error("Latency write went astray");

   // A read that meets a write returns the value from before the write,
   // since the read mux looks at the registers ahead of the update
   rd_old_a: assert property ( // see R10
      (i_rd && i_wr && i_bank_b && i_addr == HIWT_ADDR_TILT_LAT)
      |=> o_rvalid && (o_rdata == $past(o_tilt_latency)))
      else $error("Read during write did not return old value");

   rvalid_pulse_a: assert property ( // see R2
      o_rvalid == $past(i_rd))
      else $error("Read valid not one cycle after the strobe");

   // Read data must stand until the next read strobe
   rdata_hold_a: assert property ( // see R2
      !i_rd |=> $stable(o_rdata))
      else $error("Read data changed without a read");

   wr_offs_c: cover property (
      i_wr && !i_bank_b && i_addr == HIWT_OFFS_ADDR[0]);
   rd_mask_c: cover property (
      i_rd && i_bank_b && i_addr == HIWT_ADDR_TILT_MASK);
   bank_swap_c: cover property (
      (i_wr && !i_bank_b) ##[1:20] (i_wr && i_bank_b));
   tick_c: cover property (o_tilt_latency_tick);
   rd_wr_c: cover property (
      i_rd && i_wr && i_bank_b && i_addr == HIWT_ADDR_TILT_LAT);

endmodule

/* sim/test_hiwt_regs.sv */
// Purpose: Self-checking bench for the offset and wrist tilt register bank.
// Assumes: Inputs change 10 ns after the rising edge; tick shortened to 8.
// Notes:   Reset values first, then table rows, bank, back to back, mask, tick and second reset cases.
module test_hiwt_regs
   import hiwt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int TICK = 8;
   localparam int DLY = 10;

   typedef struct {
      logic bank;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } hiwt_row_t;

   logic i_mclk, i_rst_n, i_bank_b, i_wr, i_rd;
   logic [6:0] i_addr;
   logic [7:0] i_wdata, o_rdata, o_tilt_latency, o_tilt_threshold;
   logic o_rvalid, o_tilt_latency_tick;
   logic signed [15:0] o_x_offset, o_y_offset, o_z_offset;
   logic [5:0] o_tilt_mask;
   int mismatches = 0;
   int cmp_count = 0;
   int n;

   // Mask row writes the pad bits too, so readback must drop them
   hiwt_row_t rows [9] = '{
      '{1'b0, 7'h2D, 8'h01, 8'h01}, '{1'b0, 7'h2E, 8'h80, 8'h80},
      '{1'b0, 7'h2F, 8'hFF, 8'hFF}, '{1'b0, 7'h30, 8'h7F, 8'h7F},
      '{1'b0, 7'h31, 8'h34, 8'h34}, '{1'b0, 7'h32, 8'h12, 8'h12},
      '{1'b1, 7'h50, 8'hFF, 8'hFF}, '{1'b1, 7'h54, 8'h00, 8'h00},
      '{1'b1, 7'h59, 8'hFF, 8'hFC}
   };

   hiwt_regs #(.TICK_CYCLES(TICK)) hiwt_regs_i (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bank_b(i_bank_b),
      .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_x_offset(o_x_offset),
      .o_y_offset(o_y_offset), .o_z_offset(o_z_offset),
      .o_tilt_latency(o_tilt_latency), .o_tilt_threshold(o_tilt_threshold),
      .o_tilt_mask(o_tilt_mask), .o_tilt_latency_tick(o_tilt_latency_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock, 100 ns period
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   // Case equality so an unknown never passes
   task automatic check(logic [15:0] got, logic [15:0] exp, string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One write strobe, released after the taking edge
   task automatic wr(logic bank, logic [6:0] addr, logic [7:0] data);
      @(posedge i_mclk);
      #DLY;
      i_bank_b = bank;
      i_addr = addr;
      i_wdata = data;
      i_wr = 1'b1;
      @(posedge i_mclk);
      #DLY;
      i_wr = 1'b0;
   endtask

   // Answer is registered, so it is looked at one edge after the strobe
   task automatic rd(logic bank, logic [6:0] addr, logic [7:0] exp);
      @(posedge i_mclk);
      #DLY;
      i_bank_b = bank;
      i_addr = addr;
      i_rd = 1'b1;
      @(posedge i_mclk);
      #DLY;
      i_rd = 1'b0;
      check({15'h0, o_rvalid}, 16'h1, "read valid");
      check({8'h0, o_rdata}, {8'h0, exp}, "read data");
   endtask

   // Every register back at its power-on value
   task automatic reset_vals();
      for (int i = 0; i < 6; i++) begin
         rd(1'b0, rows[i].addr, 8'h00);
      end
      check(o_x_offset, 16'h0, "x word");
      check(o_y_offset | o_z_offset, 16'h0, "yz words");
      rd(1'b1, 7'h50, 8'h0F);
      rd(1'b1, 7'h54, 8'h20);
      rd(1'b1, 7'h59, 8'hC0);
      check({8'h0, o_tilt_latency}, 16'h0F, "latency");
      check({8'h0, o_tilt_threshold}, 16'h20, "threshold");
      check({10'h0, o_tilt_mask}, 16'h30, "mask");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog; whole run needs well under 1000 cycles
   initial begin
      #(5000 * 100);
      mismatches++;
      $display("MISMATCH t=%0t run did not finish", $time);
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      i_rst_n = 1'b0;
      i_bank_b = 1'b0;
      i_addr = 7'h00;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_wdata = 8'h00;
      repeat (6) @(posedge i_mclk);
      #DLY;
      i_rst_n = 1'b1;
      reset_vals();
      $display("test reset values done");
      foreach (rows[i]) begin
         wr(rows[i].bank, rows[i].addr, rows[i].wdata);
         rd(rows[i].bank, rows[i].addr, rows[i].rexp);
      end
      check(o_x_offset, 16'h8001, "x word");
      check(o_y_offset, 16'h7FFF, "y word");
      check(o_z_offset, 16'h1234, "z word");
      check({8'h0, o_tilt_latency}, 16'hFF, "latency");
      check({8'h0, o_tilt_threshold}, 16'h00, "threshold");
      check({10'h0, o_tilt_mask}, 16'h3F, "mask");
      $display("test table done");
      // Right address in the wrong bank, and an unmapped address: all must be ignored and read zero
      wr(1'b0, 7'h50, 8'h00);
      rd(1'b0, 7'h50, 8'h00);
      wr(1'b1, 7'h2D, 8'h55);
      rd(1'b1, 7'h2D, 8'h00);
      wr(1'b0, 7'h33, 8'hAA);
      rd(1'b0, 7'h33, 8'h00);
      check({8'h0, o_tilt_latency}, 16'hFF, "latency kept");
      check(o_x_offset, 16'h8001, "x kept");
      $display("test bank select done");
      // Negative Z word, then write and read back to back, then a read
      // that meets a write in the same cycle
      wr(1'b0, 7'h32, 8'hF2);
      check(o_z_offset, 16'hF234, "z word");
      check({15'h0, o_z_offset < 0}, 16'h1, "z sign");
      @(posedge i_mclk);
      #DLY;
      i_bank_b = 1'b0;
      i_addr = 7'h2F;
      i_wdata = 8'h5A;
      i_wr = 1'b1;
      @(posedge i_mclk);
      #DLY;
      i_wr = 1'b0;
      i_rd = 1'b1;
      @(posedge i_mclk);
      #DLY;
      i_rd = 1'b0;
      check({8'h0, o_rdata}, 16'h5A, "read after write");
      @(posedge i_mclk);
      #DLY;
      i_bank_b = 1'b1;
      i_addr = 7'h50;
      i_wdata = 8'h3C;
      i_wr = 1'b1;
      i_rd = 1'b1;
      @(posedge i_mclk);
      #DLY;
      i_wr = 1'b0;
      i_rd = 1'b0;
      check({15'h0, o_rvalid}, 16'h1, "read valid");
      check({8'h0, o_rdata}, 16'hFF, "old value");
      rd(1'b1, 7'h50, 8'h3C);
      $display("test back to back done");
      // One direction at a time, pad bits left at zero
      for (int i = 0; i < 6; i++) begin
         wr(1'b1, 7'h59, 8'(8'h04 << i));
         check({10'h0, o_tilt_mask}, 16'(16'h1 << i), "mask bit");
      end
      $display("test mask bits done");
      // Tick spacing; bounded wait for the first pulse
      n = 0;
      while (o_tilt_latency_tick !== 1'b1 && n < 20) begin
         @(posedge i_mclk);
         #DLY;
         n++;
      end
      n = 0;
      do begin
         @(posedge i_mclk);
         #DLY;
         n++;
      end while (o_tilt_latency_tick !== 1'b1 && n < 20);
      check(16'(n), 16'(TICK), "tick spacing");
      $display("test tick done");
      // Second reset in mid-run restores every value
      i_rst_n = 1'b0;
      repeat (2) @(posedge i_mclk);
      #DLY;
      i_rst_n = 1'b1;
      reset_vals();
      $display("test second reset done");
      give_verdict();
   end
endmodule
